// File: inc/cbz_pkg.sv
// Constants shared by the bus control zero block and its helpers
package cbz_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTL0   = 8'h00;  // bus_control_zero
    localparam logic [7:0] ADDR_MODE   = 8'h04;  // Mode status (init acknowledge)
    localparam logic [7:0] ADDR_ISTAT  = 8'h08;  // Sticky event status
    localparam logic [7:0] ADDR_ICLR   = 8'h0C;  // Event clear, write only
    localparam logic [7:0] ADDR_IEN    = 8'h10;  // Event enable
    localparam logic [7:0] ADDR_TIMER  = 8'h14;  // Live timer value
    localparam logic [7:0] ADDR_STAMP  = 8'h18;  // Last captured stamp

    // Field positions inside bus_control_zero
    localparam int BIT_RECEIVED_FRAME_FLAG = 7;  // received_frame_flag
    localparam int BIT_RECEIVER_ACTIVE_FLAG = 6;  // receiver_active_flag
    localparam int BIT_STOPW = 5;  // stop_in_wait
    localparam int BIT_BUS_SYNCHRONIZED_FLAG = 4;  // bus_synchronized_flag
    localparam int BIT_TIME  = 3;  // timer enable
    localparam int BIT_WAKE  = 2;  // wakeup_enable
    localparam int BIT_SLEEP = 1;  // sleep_request
    localparam int BIT_INIT  = 0;  // init_request
    localparam int BIT_INAK  = 0;  // init_acknowledge in mode register

    // Event bit positions
    localparam int EVT_N     = 3;
    localparam int EVT_RECEIVED_FRAME_FLAG = 0;  // Valid frame received
    localparam int EVT_STAMP = 1;  // Stamp written to a buffer
    localparam int EVT_SYNC  = 2;  // Synchronized flag changed

    // Reset values
    localparam logic [7:0]       CTL0_RST = 8'h00;
    localparam logic [EVT_N-1:0] EVT_RST  = 3'h0;
    localparam logic [15:0]      TMR_RST  = 16'h0000;

    // Stamp bytes in a message buffer
    localparam logic [3:0] STAMP_HI_BYTE = 4'hE;
    localparam logic [3:0] STAMP_LO_BYTE = 4'hF;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // Bus slave states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WR   = 3'h2,
        ST_RD   = 3'h4
    } cbz_bus_e;
endpackage

// File: logic/cbz_evt_irq.sv
// Sticky event status bits, set by event pulses and cleared by clear pulses
`timescale 1ns/1ps
module cbz_evt_irq (
    // Clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // Events and software control
    input  wire logic [cbz_pkg::EVT_N-1:0] evt_set,
    input  wire logic [cbz_pkg::EVT_N-1:0] evt_clr,
    // Status out
    output logic      [cbz_pkg::EVT_N-1:0] evt_status
);
    logic [cbz_pkg::EVT_N-1:0] status_ff;  // One sticky bit per event

    // Per bit: a set in the clear cycle wins, so no event is lost
    for (genvar i = 0; i < cbz_pkg::EVT_N; i++) begin : g_evt
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                status_ff[i] <= 1'b0;
            end else if (evt_set[i]) begin
                status_ff[i] <= 1'b1;
            end else if (evt_clr[i]) begin
                status_ff[i] <= 1'b0;
            end
        end
    end

    assign evt_status = status_ff;
endmodule

// File: logic/cbz_stamp_timer.sv
// Free running bit-rate timer and stamp writer into message buffers
`timescale 1ns/1ps
module cbz_stamp_timer (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Control
    input  wire logic        tmr_enable,
    input  wire logic        bit_tick,
    input  wire logic        capture,
    // Timer state
    output logic      [15:0] tmr_count,
    output logic      [15:0] stamp_last,
    // Buffer byte write port
    output logic             stamp_we,
    output logic      [3:0]  stamp_addr,
    output logic      [7:0]  stamp_byte
);
    logic [15:0] count_ff;  // Counter, zero while disabled
    logic [15:0] stamp_ff;  // Copy for low byte
    logic        lo_pend_ff; // Low byte still to be written
    logic        we_ff;
    logic [3:0]  addr_ff;
    logic [7:0]  byte_ff;

    // Counter: zero when off, +1 per bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= cbz_pkg::TMR_RST;
        end else if (!tmr_enable) begin
            count_ff <= cbz_pkg::TMR_RST;
        end else if (bit_tick) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // Stamp: high byte, then low byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stamp_ff   <= cbz_pkg::TMR_RST;
            lo_pend_ff <= 1'b0;
            we_ff      <= 1'b0;
            addr_ff    <= 4'h0;
            byte_ff    <= 8'h00;
        end else if (capture && tmr_enable) begin
            stamp_ff   <= count_ff;
            lo_pend_ff <= 1'b1;
            we_ff      <= 1'b1;
            addr_ff    <= cbz_pkg::STAMP_HI_BYTE;
            byte_ff    <= count_ff[15:8];
        end else if (lo_pend_ff) begin
            lo_pend_ff <= 1'b0;
            we_ff      <= 1'b1;
            addr_ff    <= cbz_pkg::STAMP_LO_BYTE;
            byte_ff    <= stamp_ff[7:0];
        end else begin
            we_ff      <= 1'b0;
        end
    end

    assign tmr_count  = count_ff;
    assign stamp_last = stamp_ff;
    assign stamp_we   = we_ff;
    assign stamp_addr = addr_ff;
    assign stamp_byte = byte_ff;
endmodule

// File: logic/cbz_ctl0_top.sv
// Bus control zero register, timestamp timer and AHB-Lite slave
//
// How it works
// - Register reads are registered on hclk
// - Writes outside init; status bits read-only
// - Init mode holds stop_in_wait, timer enable and flags at reset value
// - Leaving init makes register writable at once
// - Valid received frame sets received_frame_flag
// - Flag clears by writing one; zero ignored
// - Loopback leaves both receive flags meaningless
// - receiver_active_flag follows receiver front end
// - stop_in_wait gates bus clock in wait
// - bus_synchronized_flag mirrors core synchronization
// - Timer enable starts 16-bit bit-rate counter
// - Stamp written to buffer bytes at end
// - Disabled timer is cleared to zero
// - Timer enable forced low in init
// - Init acknowledge set on entering init
// - Init request not clearable before acknowledge
`timescale 1ns/1ps
module cbz_ctl0_top (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Protocol core status, same clock
    input  wire logic        rx_frame_ok,
    input  wire logic        rx_busy,
    input  wire logic        bus_synced,
    input  wire logic        bit_tick,
    input  wire logic        frame_eof_ok,
    // System low power state
    input  wire logic        wait_mode,
    // Mode control towards the core
    output logic             init_mode,
    output logic             sleep_req,
    output logic             wake_en,
    output logic             bus_clk_stop,
    // Stamp write into the active buffer
    output logic             stamp_we,
    output logic      [3:0]  stamp_addr,
    output logic      [7:0]  stamp_byte,
    // Interrupt
    output logic             irq
);
    // Bus slave state
    cbz_pkg::cbz_bus_e state_ff; // Current phase
    cbz_pkg::cbz_bus_e nxt_state; // Next phase
    logic [7:0]  addr_ff; // Latched address
    logic [31:0] rdata_ff; // Read data
    logic        ready_ff; // hreadyout
    logic        resp_ff; // Always OKAY

    // Control register fields
    logic        received_frame_flag_ff; // Sticky received frame
    logic        stopw_ff; // Stop in wait
    logic        time_ff; // Timer enable
    logic        wake_ff; // Wakeup enable
    logic        sleep_ff; // Sleep request
    logic        init_request_ff; // Init request
    logic        init_acknowledge_ff; // Init acknowledge

    // Status samples and outputs
    logic        receiver_active_flag_ff; // Receiver active
    logic        bus_synchronized_flag_ff; // Synchronized
    logic        init_mode_ff; // Init mode out
    logic        clk_stop_ff; // Clock gate request
    logic        irq_ff; // Interrupt

    // Interrupt registers and event wiring
    logic [cbz_pkg::EVT_N-1:0] ien_ff; // Event enable
    logic [cbz_pkg::EVT_N-1:0] evt_set; // Event pulses
    logic [cbz_pkg::EVT_N-1:0] evt_clr; // Clear pulses
    logic [cbz_pkg::EVT_N-1:0] evt_stat; // Sticky status

    // Timer wiring
    logic [15:0] tmr_count; // Live count
    logic [15:0] stamp_last; // Last stamp
    logic        stamp_we_w; // Stamp byte strobe

    // Decode
    logic        addr_phase; // Address phase accepted
    logic        wr_ctl0; // Control register write
    logic        in_init; // Init mode reached
    logic [7:0]  ctl0_view; // Control register as read
    logic [31:0] nxt_rdata; // Read mux

    // Accepted address phase
    assign addr_phase = hsel && hready && (htrans == cbz_pkg::HTRANS_NONSEQ);

    // Init mode: request and acknowledge high
    assign in_init = init_request_ff && init_acknowledge_ff;

    // Control register data phase
    assign wr_ctl0 = (state_ff == cbz_pkg::ST_WR) && (addr_ff == cbz_pkg::ADDR_CTL0);

    // Bus phase sequencing: writes take no wait, reads take one
    always_comb begin
        nxt_state = cbz_pkg::ST_IDLE;
        case (state_ff)
            cbz_pkg::ST_RD: begin
                nxt_state = cbz_pkg::ST_IDLE;  // Wait cycle; data phase ends next cycle
            end
            cbz_pkg::ST_IDLE,
            cbz_pkg::ST_WR: begin
                if (addr_phase && hwrite) begin
                    nxt_state = cbz_pkg::ST_WR;
                end else if (addr_phase) begin
                    nxt_state = cbz_pkg::ST_RD;
                end else begin
                    nxt_state = cbz_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = cbz_pkg::ST_IDLE;
            end
        endcase
    end

    // Phase register and latched address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= cbz_pkg::ST_IDLE;
            addr_ff  <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (addr_phase) begin
                addr_ff <= {haddr[7:2], 2'b00};  // Word aligned
            end
        end
    end

    // One wait state per read,
    // so a write just before it lands first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_ff <= 1'b1;
            resp_ff  <= cbz_pkg::HRESP_OKAY;
        end else begin
            ready_ff <= !(addr_phase && !hwrite);
            resp_ff  <= cbz_pkg::HRESP_OKAY;
        end
    end

    // Control register as software sees it
    always_comb begin
        ctl0_view = cbz_pkg::CTL0_RST;
        ctl0_view[cbz_pkg::BIT_RECEIVED_FRAME_FLAG] = received_frame_flag_ff;
        ctl0_view[cbz_pkg::BIT_RECEIVER_ACTIVE_FLAG] = receiver_active_flag_ff;
        ctl0_view[cbz_pkg::BIT_STOPW] = stopw_ff;
        ctl0_view[cbz_pkg::BIT_BUS_SYNCHRONIZED_FLAG] = bus_synchronized_flag_ff;
        ctl0_view[cbz_pkg::BIT_TIME]  = time_ff;
        ctl0_view[cbz_pkg::BIT_WAKE]  = wake_ff;
        ctl0_view[cbz_pkg::BIT_SLEEP] = sleep_ff;
        ctl0_view[cbz_pkg::BIT_INIT]  = init_request_ff;
    end

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (addr_ff)
            cbz_pkg::ADDR_CTL0: begin
                nxt_rdata[7:0] = ctl0_view;
            end
            cbz_pkg::ADDR_MODE: begin
                nxt_rdata[cbz_pkg::BIT_INAK] = init_acknowledge_ff;
            end
            cbz_pkg::ADDR_ISTAT: begin
                nxt_rdata[cbz_pkg::EVT_N-1:0] = evt_stat;
            end
            cbz_pkg::ADDR_IEN: begin
                nxt_rdata[cbz_pkg::EVT_N-1:0] = ien_ff;
            end
            cbz_pkg::ADDR_TIMER: begin
                nxt_rdata[15:0] = tmr_count;
            end
            cbz_pkg::ADDR_STAMP: begin
                nxt_rdata[15:0] = stamp_last;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data taken in the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (state_ff == cbz_pkg::ST_RD) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Init request: set any time, clear once acknowledged
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_request_ff <= 1'b0;
        end else if (wr_ctl0) begin
            if (hwdata[cbz_pkg::BIT_INIT]) begin
                init_request_ff <= 1'b1;
            end else if (init_acknowledge_ff) begin
                init_request_ff <= 1'b0;
            end
        end
    end

    // Acknowledge follows the request one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_acknowledge_ff <= 1'b0;
        end else begin
            init_acknowledge_ff <= init_request_ff;
        end
    end

    // Wakeup and sleep: written out of init only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_ff  <= 1'b0;
            sleep_ff <= 1'b0;
        end else if (wr_ctl0 && !in_init) begin
            wake_ff  <= hwdata[cbz_pkg::BIT_WAKE];
            sleep_ff <= hwdata[cbz_pkg::BIT_SLEEP];
        end
    end

    // Stop in wait and timer enable; reset value in init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stopw_ff <= 1'b0;
            time_ff  <= 1'b0;
        end else if (in_init) begin
            stopw_ff <= 1'b0;
            time_ff  <= 1'b0;
        end else if (wr_ctl0) begin
            stopw_ff <= hwdata[cbz_pkg::BIT_STOPW];
            time_ff  <= hwdata[cbz_pkg::BIT_TIME];
        end
    end

    // Received frame flag: core sets, write one clears, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            received_frame_flag_ff <= 1'b0;
        end else if (in_init) begin
            received_frame_flag_ff <= 1'b0;
        end else if (rx_frame_ok) begin
            received_frame_flag_ff <= 1'b1;
        end else if (wr_ctl0 && hwdata[cbz_pkg::BIT_RECEIVED_FRAME_FLAG]) begin
            received_frame_flag_ff <= 1'b0;
        end
    end

    // Read-only status copies; loopback meaning is not guaranteed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receiver_active_flag_ff <= 1'b0;
            bus_synchronized_flag_ff <= 1'b0;
        end else begin
            receiver_active_flag_ff <= rx_busy && !in_init;
            bus_synchronized_flag_ff <= bus_synced && !in_init;
        end
    end

    // Clock stop request to the gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_stop_ff <= 1'b0;
        end else begin
            clk_stop_ff <= wait_mode && stopw_ff;
        end
    end

    // Mode output to the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_mode_ff <= 1'b0;
        end else begin
            init_mode_ff <= in_init;
        end
    end

    // Interrupt enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ien_ff <= cbz_pkg::EVT_RST;
        end else if ((state_ff == cbz_pkg::ST_WR) && (addr_ff == cbz_pkg::ADDR_IEN)) begin
            ien_ff <= hwdata[cbz_pkg::EVT_N-1:0];
        end
    end

    // Events: frame, stamp high byte, sync change
    always_comb begin
        evt_set = cbz_pkg::EVT_RST;
        evt_set[cbz_pkg::EVT_RECEIVED_FRAME_FLAG] = rx_frame_ok && !in_init;
        evt_set[cbz_pkg::EVT_STAMP] = stamp_we_w && (stamp_addr == cbz_pkg::STAMP_HI_BYTE);
        evt_set[cbz_pkg::EVT_SYNC]  = bus_synchronized_flag_ff != (bus_synced && !in_init);
    end

    // Clear pulses from writes of ones to the clear register
    assign evt_clr = ((state_ff == cbz_pkg::ST_WR) && (addr_ff == cbz_pkg::ADDR_ICLR))
                     ? hwdata[cbz_pkg::EVT_N-1:0] : cbz_pkg::EVT_RST;

    // Level interrupt, registered for a clean output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(evt_stat & ien_ff);
        end
    end

    // Sticky event status
    cbz_evt_irq u_evt (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .evt_set    (evt_set),
        .evt_clr    (evt_clr),
        .evt_status (evt_stat)
    );

    // Timer and stamp writer, tx and rx frames alike
    cbz_stamp_timer u_tmr (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .tmr_enable (time_ff),
        .bit_tick   (bit_tick),
        .capture    (frame_eof_ok),
        .tmr_count  (tmr_count),
        .stamp_last (stamp_last),
        .stamp_we   (stamp_we_w),
        .stamp_addr (stamp_addr),
        .stamp_byte (stamp_byte)
    );

    // Output connections, all from flip-flops
    assign hrdata       = rdata_ff;
    assign hreadyout    = ready_ff;
    assign hresp        = resp_ff;
    assign init_mode    = init_mode_ff;
    assign sleep_req    = sleep_ff;
    assign wake_en      = wake_ff;
    assign bus_clk_stop = clk_stop_ff;
    assign stamp_we     = stamp_we_w;
    assign irq          = irq_ff;
endmodule

// File: verification/cbz_ctl0_chk.sv
// Port-level assertions for the bus control zero block
`timescale 1ns/1ps
module cbz_ctl0_chk (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Bus request and answer
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    // Mode and stamp signals, with the wait_mode and frame_eof_ok inputs
    input wire logic       wait_mode,
    input wire logic       init_mode,
    input wire logic       sleep_req,
    input wire logic       wake_en,
    input wire logic       bus_clk_stop,
    input wire logic       frame_eof_ok,
    input wire logic       stamp_we,
    input wire logic [3:0] stamp_addr
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Accepted address phase
    sequence s_ap; hsel && hready && htrans == cbz_pkg::HTRANS_NONSEQ; endsequence
    // Two halves of one stamp
    sequence s_hi; stamp_we && stamp_addr == cbz_pkg::STAMP_HI_BYTE; endsequence
    sequence s_lo; stamp_we && stamp_addr == cbz_pkg::STAMP_LO_BYTE; endsequence
    // Settled init, two cycles deep so the entry edge is skipped
    sequence s_init; init_mode && $past(init_mode); endsequence
    property p_read_wait; s_ap ##0 !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    property p_write_zero; s_ap ##0 hwrite |=> hreadyout; endproperty
    property p_stamp_pair; s_hi |=> s_lo; endproperty
    property p_stamp_cause; s_hi |-> $past(frame_eof_ok); endproperty
    property p_stamp_init; s_init ##0 $past(init_mode, 2) |-> !stamp_we; endproperty
    property p_stop_idle; !wait_mode |=> !bus_clk_stop; endproperty
    property p_init_stop; s_init |-> !bus_clk_stop; endproperty
    property p_exempt_hold; s_init |-> $stable(wake_en) && $stable(sleep_req); endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait off");
    a_write_zero: assert property (p_write_zero) else $error("write stalled");
    a_stamp_pair: assert property (p_stamp_pair) else $error("no low byte");
    a_stamp_cause: assert property (p_stamp_cause) else $error("stamp uncaused");
    a_stamp_init: assert property (p_stamp_init) else $error("stamp in init");
    a_stop_idle: assert property (p_stop_idle) else $error("stop outside wait");
    a_init_stop: assert property (p_init_stop) else $error("stop in init");
    a_exempt_hold: assert property (p_exempt_hold) else $error("exempt bits moved");
endmodule
bind cbz_ctl0_top cbz_ctl0_chk cbz_ctl0_chk_i (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .wait_mode, .init_mode, .sleep_req, .wake_en, .bus_clk_stop, .frame_eof_ok,
    .stamp_we, .stamp_addr);

// File: verification/cbz_core_model.sv
// Behavioural protocol core: bit clock, bus sync and received frames
`timescale 1ns/1ps
module cbz_core_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Bench control
    input  wire logic slow,
    input  wire logic send_frame,
    input  wire logic init_mode,
    // Core status
    output logic      bit_tick,
    output logic      rx_busy,
    output logic      bus_synced,
    output logic      rx_frame_ok,
    output logic      frame_eof_ok
);
    logic [2:0] div_ff;   // Bit divider
    logic [3:0] idle_ff;  // Idle bits since restart
    logic [3:0] bits_ff;  // Bits left in the frame
    // Free running bit clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff   <= 3'h0;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= (div_ff == 3'h0);
            div_ff   <= (div_ff != 3'h0) ? div_ff - 3'h1 : (slow ? 3'h4 : 3'h1);
        end
    end
    // Sync after eleven idle bits; lost in init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn || init_mode) begin
            idle_ff    <= 4'h0;
            bus_synced <= 1'b0;
        end else begin
            if (bit_tick && idle_ff != 4'hB) idle_ff <= idle_ff + 4'h1;
            bus_synced <= (idle_ff == 4'hB);
        end
    end
    // Eight bit frame; end pulses both flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bits_ff      <= 4'h0;
            rx_busy      <= 1'b0;
            rx_frame_ok  <= 1'b0;
            frame_eof_ok <= 1'b0;
        end else begin
            rx_frame_ok  <= 1'b0;
            frame_eof_ok <= 1'b0;
            if (send_frame && bus_synced && !rx_busy) begin
                rx_busy <= 1'b1;
                bits_ff <= 4'h8;
            end else if (rx_busy && bit_tick) begin
                bits_ff <= bits_ff - 4'h1;
                if (bits_ff == 4'h1) begin
                    rx_busy      <= 1'b0;
                    rx_frame_ok  <= 1'b1;
                    frame_eof_ok <= 1'b1;
                end
            end
        end
    end
endmodule

// File: verification/cbz_ctl0_top_test.sv
// Self-checking bench for the bus control zero block
`timescale 1ns/1ps
module cbz_ctl0_top_test;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic rx_frame_ok, rx_busy, bus_synced, bit_tick, frame_eof_ok, wait_mode, slow, send_frame;
    logic init_mode, sleep_req, wake_en, bus_clk_stop, stamp_we;
    logic [7:0]  haddr, v, sh, sl;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  stamp_addr;
    logic [7:0]  stamp_byte;
    logic [31:0] hwdata, hrdata, r, t;
    int          n_mismatch, n_tests, i;
    localparam logic [7:0] CT0 = cbz_pkg::ADDR_CTL0, IEN = cbz_pkg::ADDR_IEN, TMR = cbz_pkg::ADDR_TIMER;
    assign hready = hreadyout;  // Single slave drives the bus ready
    cbz_ctl0_top cbz_ctl0_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .rx_frame_ok, .rx_busy, .bus_synced, .bit_tick,
        .frame_eof_ok, .wait_mode, .init_mode, .sleep_req, .wake_en, .bus_clk_stop, .stamp_we,
        .stamp_addr, .stamp_byte, .irq);
    cbz_core_model cbz_core_model_i (.hclk, .hresetn, .slow, .send_frame, .init_mode, .bit_tick,
        .rx_busy, .bus_synced, .rx_frame_ok, .frame_eof_ok);
    // 50 MHz clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Last stamp bytes on the buffer port
    always @(posedge hclk) if (stamp_we === 1'b1) begin
        if (stamp_addr == cbz_pkg::STAMP_HI_BYTE) sh <= stamp_byte;
        else sl <= stamp_byte;
    end
    task automatic test_done;
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Address phase, then data phase, each held until ready
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= cbz_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, t);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 32'h0, r);
    endtask
    // Expected control word
    function automatic logic [31:0] ctl(input logic [7:0] w, input logic busy, input logic syn);
        return {24'h0, (w & 8'hAF) | {1'b0, busy, 1'b0, syn, 4'h0}};
    endfunction
    // Watchdog, far beyond the planned run
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        test_done();
    end
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, wait_mode, slow, send_frame} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        void'($urandom(12113));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(CT0); check("ctl0 reset", 32'h0, r);
        wr(8'h1C, $urandom);
        rd(8'h1C); check("unmapped", 32'h0, r);
        repeat (40) @(posedge hclk);
        // Random writes; read-only and sticky bits stay
        for (i = 0; i < 6; i++) begin
            v = $urandom & 8'hFE;
            wr(CT0, {24'h0, v});
            rd(CT0); check("ctl0 rw", ctl(v & 8'h2E, 1'b0, 1'b1), r);
            check("wake", {31'h0, v[2]}, {31'h0, wake_en});
            check("sleep", {31'h0, v[1]}, {31'h0, sleep_req});
        end
        // Frame, timer on, frame event enabled
        wr(CT0, 32'h08);
        wr(IEN, 32'h1);
        slow <= 1'b1;
        send_frame <= 1'b1;
        @(posedge hclk);
        send_frame <= 1'b0;
        rd(CT0); check("receiving", ctl(8'h08, 1'b1, 1'b1), r);
        for (i = 0; i < 200 && irq !== 1'b1; i++) @(posedge hclk);
        check("irq", 32'h1, {31'h0, irq});
        rd(CT0); check("frame flag", ctl(8'h88, 1'b0, 1'b1), r);
        rd(cbz_pkg::ADDR_ISTAT); check("status", 32'h7, r);
        rd(cbz_pkg::ADDR_STAMP); check("stamp", {16'h0, sh, sl}, r);
        wr(CT0, 32'h08);
        rd(CT0); check("flag kept", ctl(8'h88, 1'b0, 1'b1), r);
        wr(CT0, 32'h88);
        rd(CT0); check("flag cleared", ctl(8'h08, 1'b0, 1'b1), r);
        wr(IEN, 32'h0);
        repeat (2) @(posedge hclk);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(IEN, 32'h1);
        wr(cbz_pkg::ADDR_ICLR, 32'h7);
        repeat (2) @(posedge hclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        // Timer runs, clears when off
        rd(TMR);
        t = r;
        repeat (30) @(posedge hclk);
        rd(TMR); check("timer runs", 32'h1, {31'h0, r > t});
        wr(CT0, 32'h0);
        rd(TMR); check("timer off", 32'h0, r);
        // Init entry, frozen fields, exit
        wr(CT0, 32'h2E);
        wr(CT0, 32'h2F);
        rd(cbz_pkg::ADDR_MODE); check("init ack", 32'h1, r);
        rd(CT0); check("init hold", 32'h07, r);
        wr(CT0, 32'h29);
        rd(CT0); check("init write", 32'h07, r);
        rd(TMR); check("init timer", 32'h0, r);
        wr(CT0, 32'h0);
        rd(cbz_pkg::ADDR_MODE); check("init left", 32'h0, r);
        wr(CT0, 32'h28);
        rd(CT0); check("writable", 32'h28, r);
        // Wait mode, clock stop on and off
        wait_mode <= 1'b1;
        repeat (2) @(posedge hclk);
        check("clock stop", 32'h1, {31'h0, bus_clk_stop});
        wr(CT0, 32'h08);
        repeat (2) @(posedge hclk);
        check("clock runs", 32'h0, {31'h0, bus_clk_stop});
        wait_mode <= 1'b0;
        test_done();
    end
endmodule
